/* alod_pkg.sv */
// constants and carrier types for the arithmetic/logic opcode decoder
package alod_pkg;

  localparam int CYC_W = 9;

  // opcode patterns, low bit(s) masked where w/d/s live
  localparam logic [7:0] OPC_GRP3 = 8'hF6;
  localparam logic [7:0] OPC_SIGNED_MULTIPLY_IMM = 8'h69;
  localparam logic [7:0] OPC_ADJ_MUL = 8'hD4;
  localparam logic [7:0] OPC_ADJ_DIV = 8'hD5;
  localparam logic [7:0] OPC_ADJ_BASE = 8'h0A;
  localparam logic [7:0] OPC_CBW = 8'h98;
  localparam logic [7:0] OPC_CWD = 8'h99;
  localparam logic [7:0] OPC_SHF_ONE = 8'hD0;
  localparam logic [7:0] OPC_SHF_CNT = 8'hD2;
  localparam logic [7:0] OPC_SHF_IMM = 8'hC0;
  localparam logic [7:0] OPC_AND_RM = 8'h20;
  localparam logic [7:0] OPC_OR_RM = 8'h08;
  localparam logic [7:0] OPC_XOR_RM = 8'h30;
  localparam logic [7:0] OPC_TEST_RM = 8'h84;
  localparam logic [7:0] OPC_TEST_ACC = 8'hA8;
  localparam logic [7:0] OPC_GRP1 = 8'h80;
  localparam logic [7:0] OPC_AND_ACC = 8'h24;
  localparam logic [7:0] OPC_OR_ACC = 8'h0C;
  localparam logic [7:0] OPC_XOR_ACC = 8'h34;

  // modrm reg field values, and the mod value for register operands
  localparam logic [2:0] REG_TEST = 3'h0;
  localparam logic [2:0] REG_OR = 3'h1;
  localparam logic [2:0] REG_NOT = 3'h2;
  localparam logic [2:0] REG_AND = 3'h4;
  localparam logic [2:0] REG_SIGNED_MULTIPLY = 3'h5;
  localparam logic [2:0] REG_DIV = 3'h6;
  localparam logic [2:0] REG_SIGNED_DIVIDE = 3'h7;
  localparam logic [1:0] MOD_REG = 2'h3;

  // clock-cycle costs
  localparam logic [CYC_W-1:0] C_SIGNED_MULTIPLY_RB_MIN = 9'h019;
  localparam logic [CYC_W-1:0] C_SIGNED_MULTIPLY_RB_MAX = 9'h01C;
  localparam logic [CYC_W-1:0] C_SIGNED_MULTIPLY_RW_MIN = 9'h022;
  localparam logic [CYC_W-1:0] C_SIGNED_MULTIPLY_RW_MAX = 9'h025;
  localparam logic [CYC_W-1:0] C_SIGNED_MULTIPLY_MB_MIN = 9'h01F;
  localparam logic [CYC_W-1:0] C_SIGNED_MULTIPLY_MB_MAX = 9'h022;
  localparam logic [CYC_W-1:0] C_SIGNED_MULTIPLY_MW_MIN = 9'h028;
  localparam logic [CYC_W-1:0] C_SIGNED_MULTIPLY_MW_MAX = 9'h02B;
  localparam logic [CYC_W-1:0] C_IMMUL_R_MIN = 9'h016;
  localparam logic [CYC_W-1:0] C_IMMUL_R_MAX = 9'h019;
  localparam logic [CYC_W-1:0] C_IMMUL_M_MIN = 9'h01D;
  localparam logic [CYC_W-1:0] C_IMMUL_M_MAX = 9'h020;
  localparam logic [CYC_W-1:0] C_DIV_RB = 9'h01D;
  localparam logic [CYC_W-1:0] C_DIV_RW = 9'h026;
  localparam logic [CYC_W-1:0] C_DIV_MB = 9'h023;
  localparam logic [CYC_W-1:0] C_DIV_MW = 9'h02C;
  localparam logic [CYC_W-1:0] C_SIGNED_DIVIDE_RB_MIN = 9'h02C;
  localparam logic [CYC_W-1:0] C_SIGNED_DIVIDE_RB_MAX = 9'h034;
  localparam logic [CYC_W-1:0] C_SIGNED_DIVIDE_RW_MIN = 9'h035;
  localparam logic [CYC_W-1:0] C_SIGNED_DIVIDE_RW_MAX = 9'h03D;
  localparam logic [CYC_W-1:0] C_SIGNED_DIVIDE_MB_MIN = 9'h032;
  localparam logic [CYC_W-1:0] C_SIGNED_DIVIDE_MB_MAX = 9'h03A;
  localparam logic [CYC_W-1:0] C_SIGNED_DIVIDE_MW_MIN = 9'h03B;
  localparam logic [CYC_W-1:0] C_SIGNED_DIVIDE_MW_MAX = 9'h043;
  localparam logic [CYC_W-1:0] C_ADJ_MUL = 9'h013;
  localparam logic [CYC_W-1:0] C_ADJ_DIV = 9'h00F;
  localparam logic [CYC_W-1:0] C_CBW = 9'h002;
  localparam logic [CYC_W-1:0] C_CWD = 9'h004;
  localparam logic [CYC_W-1:0] C_SHF1_R = 9'h002;
  localparam logic [CYC_W-1:0] C_SHF1_M = 9'h00F;
  localparam logic [CYC_W-1:0] C_SHFN_R = 9'h005;
  localparam logic [CYC_W-1:0] C_SHFN_M = 9'h011;
  localparam logic [CYC_W-1:0] C_LOG_R = 9'h003;
  localparam logic [CYC_W-1:0] C_LOG_M = 9'h00A;
  localparam logic [CYC_W-1:0] C_TESTI_R = 9'h004;
  localparam logic [CYC_W-1:0] C_IMMRM_R = 9'h004;
  localparam logic [CYC_W-1:0] C_IMMRM_M = 9'h010;
  localparam logic [CYC_W-1:0] C_ACC_B = 9'h003;
  localparam logic [CYC_W-1:0] C_ACC_W = 9'h004;
  localparam logic [CYC_W-1:0] C_WORD_MEM = 9'h004;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_SIGNED_MULTIPLY = 5'h01,
    OP_IMM_MULTIPLY = 5'h02,
    OP_UNSIGNED_DIVIDE = 5'h03,
    OP_SIGNED_DIVIDE = 5'h04,
    OP_ASCII_ADJUST_AFTER_MULTIPLY = 5'h05,
    OP_ASCII_ADJUST_BEFORE_DIVIDE = 5'h06,
    OP_BYTE_TO_WORD_EXTEND = 5'h07,
    OP_WORD_TO_DWORD_EXTEND = 5'h08,
    OP_SHIFT = 5'h09,
    OP_AND = 5'h0A,
    OP_OR = 5'h0B,
    OP_XOR = 5'h0C,
    OP_TEST = 5'h0D,
    OP_INVERT = 5'h0E
  } alod_op_type;

  typedef enum logic [2:0] {
    SH_ROTATE_LEFT = 3'h0,
    SH_ROTATE_RIGHT = 3'h1,
    SH_ROTATE_LEFT_THROUGH_CARRY = 3'h2,
    SH_ROTATE_RIGHT_THROUGH_CARRY = 3'h3,
    SH_SHIFT_LEFT = 3'h4,
    SH_LOGICAL_SHIFT_RIGHT = 3'h5,
    SH_RESERVED = 3'h6,
    SH_ARITHMETIC_SHIFT_RIGHT = 3'h7
  } alod_shift_type;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic [7:0] count;
  } alod_req_type;

  typedef struct packed {
    logic valid;
    logic known;
    alod_op_type op;
    alod_shift_type shift_op;
    logic word;
    logic mem;
    logic writes_result;
    logic [1:0] imm_bytes;
    logic [CYC_W-1:0] cyc_min;
    logic [CYC_W-1:0] cyc_max;
  } alod_dec_type;

endpackage

/* alod_decoder.sv */
// opcode decoder and cycle-cost table for multiply/divide/shift/logic group
`timescale 1ns/10ps
module alod_decoder (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // instruction bytes from fetch
  input alod_pkg::alod_req_type req,
  // decoded result, one cycle later
  output alod_pkg::alod_dec_type dec
);

  alod_pkg::alod_dec_type dec_d;
  alod_pkg::alod_dec_type dec_q;

  logic w_bit;
  logic is_mem;
  logic [2:0] reg_fld;
  logic [alod_pkg::CYC_W-1:0] n_cnt;

  assign w_bit = req.opcode[0];
  assign is_mem = req.modrm[7:6] != alod_pkg::MOD_REG;
  assign reg_fld = req.modrm[5:3];
  assign n_cnt = {1'b0, req.count};

  always_comb begin
    dec_d = '0;
    dec_d.valid = req.valid;
    dec_d.known = 1'b1;
    dec_d.op = alod_pkg::OP_NONE;
    dec_d.shift_op = alod_pkg::SH_ROTATE_LEFT;
    dec_d.word = w_bit;
    dec_d.mem = is_mem;
    dec_d.writes_result = 1'b1;
    if (req.opcode[7:1] == alod_pkg::OPC_GRP3[7:1]) begin
      case (reg_fld)
        alod_pkg::REG_SIGNED_MULTIPLY: begin
          dec_d.op = alod_pkg::OP_SIGNED_MULTIPLY;
          case ({is_mem, w_bit})
            2'h0: begin
              dec_d.cyc_min = alod_pkg::C_SIGNED_MULTIPLY_RB_MIN;
              dec_d.cyc_max = alod_pkg::C_SIGNED_MULTIPLY_RB_MAX;
            end
            2'h1: begin
              dec_d.cyc_min = alod_pkg::C_SIGNED_MULTIPLY_RW_MIN;
              dec_d.cyc_max = alod_pkg::C_SIGNED_MULTIPLY_RW_MAX;
            end
            2'h2: begin
              dec_d.cyc_min = alod_pkg::C_SIGNED_MULTIPLY_MB_MIN;
              dec_d.cyc_max = alod_pkg::C_SIGNED_MULTIPLY_MB_MAX;
            end
            default: begin
              dec_d.cyc_min = alod_pkg::C_SIGNED_MULTIPLY_MW_MIN;
              dec_d.cyc_max = alod_pkg::C_SIGNED_MULTIPLY_MW_MAX;
            end
          endcase
        end
        alod_pkg::REG_DIV: begin
          dec_d.op = alod_pkg::OP_UNSIGNED_DIVIDE;
          case ({is_mem, w_bit})
            2'h0: dec_d.cyc_min = alod_pkg::C_DIV_RB;
            2'h1: dec_d.cyc_min = alod_pkg::C_DIV_RW;
            2'h2: dec_d.cyc_min = alod_pkg::C_DIV_MB;
            default: dec_d.cyc_min = alod_pkg::C_DIV_MW;
          endcase
          dec_d.cyc_max = dec_d.cyc_min;
        end
        alod_pkg::REG_SIGNED_DIVIDE: begin
          dec_d.op = alod_pkg::OP_SIGNED_DIVIDE;
          case ({is_mem, w_bit})
            2'h0: begin
              dec_d.cyc_min = alod_pkg::C_SIGNED_DIVIDE_RB_MIN;
              dec_d.cyc_max = alod_pkg::C_SIGNED_DIVIDE_RB_MAX;
            end
            2'h1: begin
              dec_d.cyc_min = alod_pkg::C_SIGNED_DIVIDE_RW_MIN;
              dec_d.cyc_max = alod_pkg::C_SIGNED_DIVIDE_RW_MAX;
            end
            2'h2: begin
              dec_d.cyc_min = alod_pkg::C_SIGNED_DIVIDE_MB_MIN;
              dec_d.cyc_max = alod_pkg::C_SIGNED_DIVIDE_MB_MAX;
            end
            default: begin
              dec_d.cyc_min = alod_pkg::C_SIGNED_DIVIDE_MW_MIN;
              dec_d.cyc_max = alod_pkg::C_SIGNED_DIVIDE_MW_MAX;
            end
          endcase
        end
        alod_pkg::REG_TEST: begin
          dec_d.op = alod_pkg::OP_TEST;
          dec_d.writes_result = 1'b0;
          dec_d.imm_bytes = w_bit ? 2'h2 : 2'h1;
          dec_d.cyc_min = is_mem ? alod_pkg::C_LOG_M : alod_pkg::C_TESTI_R;
          dec_d.cyc_max = dec_d.cyc_min;
        end
        alod_pkg::REG_NOT: begin
          dec_d.op = alod_pkg::OP_INVERT;
          dec_d.cyc_min = is_mem ? alod_pkg::C_LOG_M : alod_pkg::C_LOG_R;
          dec_d.cyc_max = dec_d.cyc_min;
        end
        default: dec_d.known = 1'b0;
      endcase
    end else if (req.opcode[7:2] == alod_pkg::OPC_SIGNED_MULTIPLY_IMM[7:2] &&
                 req.opcode[0]) begin
      dec_d.op = alod_pkg::OP_IMM_MULTIPLY;
      dec_d.word = 1'b1;
      dec_d.imm_bytes = req.opcode[1] ? 2'h1 : 2'h2;
      dec_d.cyc_min = is_mem ? alod_pkg::C_IMMUL_M_MIN
                             : alod_pkg::C_IMMUL_R_MIN;
      dec_d.cyc_max = is_mem ? alod_pkg::C_IMMUL_M_MAX
                             : alod_pkg::C_IMMUL_R_MAX;
    end else if (req.opcode == alod_pkg::OPC_ADJ_MUL ||
                 req.opcode == alod_pkg::OPC_ADJ_DIV) begin
      // both adjust forms need the fixed base byte as second byte
      dec_d.known = req.modrm == alod_pkg::OPC_ADJ_BASE;
      dec_d.word = 1'b0;
      dec_d.mem = 1'b0;
      if (req.opcode[0]) begin
        dec_d.op = alod_pkg::OP_ASCII_ADJUST_BEFORE_DIVIDE;
        dec_d.cyc_min = alod_pkg::C_ADJ_DIV;
      end else begin
        dec_d.op = alod_pkg::OP_ASCII_ADJUST_AFTER_MULTIPLY;
        dec_d.cyc_min = alod_pkg::C_ADJ_MUL;
      end
      dec_d.cyc_max = dec_d.cyc_min;
    end else if (req.opcode == alod_pkg::OPC_CBW) begin
      dec_d.op = alod_pkg::OP_BYTE_TO_WORD_EXTEND;
      dec_d.word = 1'b0;
      dec_d.mem = 1'b0;
      dec_d.cyc_min = alod_pkg::C_CBW;
      dec_d.cyc_max = alod_pkg::C_CBW;
    end else if (req.opcode == alod_pkg::OPC_CWD) begin
      dec_d.op = alod_pkg::OP_WORD_TO_DWORD_EXTEND;
      dec_d.word = 1'b1;
      dec_d.mem = 1'b0;
      dec_d.cyc_min = alod_pkg::C_CWD;
      dec_d.cyc_max = alod_pkg::C_CWD;
    end else if (req.opcode[7:1] == alod_pkg::OPC_SHF_ONE[7:1]) begin
      dec_d.op = alod_pkg::OP_SHIFT;
      dec_d.shift_op = alod_pkg::alod_shift_type'(reg_fld);
      dec_d.known = reg_fld != 3'h6;
      dec_d.cyc_min = is_mem ? alod_pkg::C_SHF1_M : alod_pkg::C_SHF1_R;
      dec_d.cyc_max = dec_d.cyc_min;
    end else if (req.opcode[7:1] == alod_pkg::OPC_SHF_CNT[7:1] ||
                 req.opcode[7:1] == alod_pkg::OPC_SHF_IMM[7:1]) begin
      dec_d.op = alod_pkg::OP_SHIFT;
      dec_d.shift_op = alod_pkg::alod_shift_type'(reg_fld);
      dec_d.known = reg_fld != 3'h6;
      dec_d.imm_bytes = req.opcode[4] ? 2'h0 : 2'h1;
      // n is the count byte, from the count register or the immediate
      dec_d.cyc_min = (is_mem ? alod_pkg::C_SHFN_M : alod_pkg::C_SHFN_R)
                      + n_cnt;
      dec_d.cyc_max = dec_d.cyc_min;
    end else if (req.opcode[7:2] == alod_pkg::OPC_AND_RM[7:2] ||
                 req.opcode[7:2] == alod_pkg::OPC_OR_RM[7:2] ||
                 req.opcode[7:2] == alod_pkg::OPC_XOR_RM[7:2]) begin
      case (req.opcode[5:4])
        2'h2: dec_d.op = alod_pkg::OP_AND;
        2'h3: dec_d.op = alod_pkg::OP_XOR;
        default: dec_d.op = alod_pkg::OP_OR;
      endcase
      dec_d.cyc_min = is_mem ? alod_pkg::C_LOG_M : alod_pkg::C_LOG_R;
      dec_d.cyc_max = dec_d.cyc_min;
    end else if (req.opcode[7:1] == alod_pkg::OPC_TEST_RM[7:1]) begin
      dec_d.op = alod_pkg::OP_TEST;
      dec_d.writes_result = 1'b0;
      dec_d.cyc_min = is_mem ? alod_pkg::C_LOG_M : alod_pkg::C_LOG_R;
      dec_d.cyc_max = dec_d.cyc_min;
    end else if (req.opcode[7:1] == alod_pkg::OPC_TEST_ACC[7:1]) begin
      dec_d.op = alod_pkg::OP_TEST;
      dec_d.writes_result = 1'b0;
      dec_d.mem = 1'b0;
      dec_d.imm_bytes = w_bit ? 2'h2 : 2'h1;
      dec_d.cyc_min = w_bit ? alod_pkg::C_ACC_W : alod_pkg::C_ACC_B;
      dec_d.cyc_max = dec_d.cyc_min;
    end else if (req.opcode[7:2] == alod_pkg::OPC_GRP1[7:2]) begin
      case (reg_fld)
        alod_pkg::REG_AND: dec_d.op = alod_pkg::OP_AND;
        alod_pkg::REG_OR: dec_d.op = alod_pkg::OP_OR;
        alod_pkg::REG_DIV: dec_d.op = alod_pkg::OP_XOR;
        default: dec_d.known = 1'b0;
      endcase
      // sign-extended byte form carries only one data byte
      dec_d.imm_bytes = req.opcode[1:0] == 2'h1 ? 2'h2 : 2'h1;
      dec_d.cyc_min = is_mem ? alod_pkg::C_IMMRM_M : alod_pkg::C_IMMRM_R;
      dec_d.cyc_max = dec_d.cyc_min;
    end else if (req.opcode[7:1] == alod_pkg::OPC_AND_ACC[7:1] ||
                 req.opcode[7:1] == alod_pkg::OPC_OR_ACC[7:1] ||
                 req.opcode[7:1] == alod_pkg::OPC_XOR_ACC[7:1]) begin
      case (req.opcode[5:4])
        2'h2: dec_d.op = alod_pkg::OP_AND;
        2'h3: dec_d.op = alod_pkg::OP_XOR;
        default: dec_d.op = alod_pkg::OP_OR;
      endcase
      dec_d.mem = 1'b0;
      dec_d.imm_bytes = w_bit ? 2'h2 : 2'h1;
      dec_d.cyc_min = w_bit ? alod_pkg::C_ACC_W : alod_pkg::C_ACC_B;
      dec_d.cyc_max = dec_d.cyc_min;
    end else begin
      dec_d.known = 1'b0;
    end
    // listed single memory figures are byte ones; the multiply and
    // divide forms already list their own word-memory figures, and
    // the word-only immediate multiply keeps its figures as listed
    if (dec_d.mem && dec_d.word && dec_d.known &&
        dec_d.op != alod_pkg::OP_SIGNED_MULTIPLY &&
        dec_d.op != alod_pkg::OP_IMM_MULTIPLY &&
        dec_d.op != alod_pkg::OP_UNSIGNED_DIVIDE &&
        dec_d.op != alod_pkg::OP_SIGNED_DIVIDE) begin
      dec_d.cyc_min = dec_d.cyc_min + alod_pkg::C_WORD_MEM;
      dec_d.cyc_max = dec_d.cyc_max + alod_pkg::C_WORD_MEM;
    end
    if (!dec_d.known) begin
      dec_d.op = alod_pkg::OP_NONE;
      dec_d.imm_bytes = 2'h0;
      dec_d.cyc_min = '0;
      dec_d.cyc_max = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dec_q <= '0;
    end else begin
      dec_q <= dec_d;
    end
  end

  assign dec = dec_q;

endmodule

/* alod_checker.sv */
// concurrent checks on the decoder ports
`timescale 1ns/10ps
module alod_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // observed ports
  input alod_pkg::alod_req_type req,
  input alod_pkg::alod_dec_type dec
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_cbw;
    req.valid && req.opcode == 8'h98 |=> dec.valid && dec.known &&
      dec.op == alod_pkg::OP_BYTE_TO_WORD_EXTEND && dec.cyc_max == 9'h002;
  endproperty
  a_cbw: assert property (p_cbw) else $error("byte extend cost");
  property p_cwd;
    req.valid && req.opcode == 8'h99 |=> dec.cyc_min == 9'h004 &&
      dec.cyc_max == 9'h004 && dec.op == alod_pkg::OP_WORD_TO_DWORD_EXTEND;
  endproperty
  a_cwd: assert property (p_cwd) else $error("word extend cost");
  property p_adj_mul;
    req.valid && req.opcode == 8'hD4 && req.modrm == 8'h0A
      |=> dec.known && dec.cyc_min == 9'h013 && dec.cyc_max == 9'h013;
  endproperty
  a_adj_mul: assert property (p_adj_mul) else $error("adjust mul");
  property p_adj_div;
    req.valid && req.opcode == 8'hD5 && req.modrm == 8'h0A
      |=> dec.op == alod_pkg::OP_ASCII_ADJUST_BEFORE_DIVIDE
      && dec.cyc_min == 9'h00F;
  endproperty
  a_adj_div: assert property (p_adj_div) else $error("adjust div");
  property p_div_rb;
    req.valid && req.opcode == 8'hF6 && req.modrm[7:3] == 5'h1E
      |=> dec.cyc_min == 9'h01D && dec.cyc_max == 9'h01D;
  endproperty
  a_div_rb: assert property (p_div_rb) else $error("divide cost");
  property p_shf_one;
    req.valid && req.opcode[7:1] == 7'h68 && req.modrm[7:6] == 2'h3 &&
      req.modrm[5:3] != 3'h6 |=> dec.known && dec.cyc_max == 9'h002;
  endproperty
  a_shf_one: assert property (p_shf_one)
    else $error("shift by one");
  property p_shf_field;
    req.valid && req.opcode[7:2] == 6'h34 && req.modrm[5:3] != 3'h6
      |=> dec.shift_op == $past(req.modrm[5:3]);
  endproperty
  a_shf_field: assert property (p_shf_field)
    else $error("shift kind");
  property p_test_rm;
    req.valid && req.opcode[7:1] == 7'h42 |=> dec.known &&
      !dec.writes_result ##1 dec.valid == $past(req.valid);
  endproperty
  a_test_rm: assert property (p_test_rm)
    else $error("test no result");
  property p_word_mem;
    req.valid && req.opcode == 8'h21 && req.modrm[7:6] != 2'h3
      |=> dec.cyc_min == 9'h00E;
  endproperty
  a_word_mem: assert property (p_word_mem)
    else $error("word mem add");
  property p_imm_mul;
    req.valid && req.opcode == 8'h6B && req.modrm[7:6] != 2'h3
      |=> dec.cyc_min == 9'h01D && dec.cyc_max == 9'h020;
  endproperty
  a_imm_mul: assert property (p_imm_mul)
    else $error("imm multiply cost");
  c_shift_field: cover property (req.valid && req.opcode == 8'hD2);
endmodule

bind alod_decoder alod_checker i_alod_checker (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .req(req),
  .dec(dec)
);

/* tb_top.sv */
// self-checking bench for the opcode decoder
`timescale 1ns/10ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  alod_pkg::alod_req_type req = '0;
  alod_pkg::alod_dec_type dec;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;

  alod_decoder i_alod_decoder (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .req(req),
    .dec(dec)
  );

  always #2 clk_sys = ~clk_sys;

  // hang guard, far above the sixty-three cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [8:0] seen,
                     input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask

  // drive at falling edge, judge at the next falling edge
  task automatic dchk(input logic [7:0] opc, input logic [7:0] mrm,
                      input logic [7:0] cnt, input alod_pkg::alod_op_type op,
                      input logic [8:0] mn, input logic [8:0] mx);
    req.valid = 1'b1;
    req.opcode = opc;
    req.modrm = mrm;
    req.count = cnt;
    @(negedge clk_sys);
    chk("valid", 9'(dec.valid), 9'h001);
    chk("known", 9'(dec.known), 9'(op != alod_pkg::OP_NONE));
    chk("op", 9'(dec.op), 9'(op));
    chk("cyc_min", dec.cyc_min, mn);
    chk("cyc_max", dec.cyc_max, mx);
  endtask

  task automatic t_muldiv();
    dchk(8'hF7, 8'hE8, 8'h00, alod_pkg::OP_SIGNED_MULTIPLY,
         9'h022, 9'h025);
    chk("word", 9'(dec.word), 9'h001);
    chk("mem", 9'(dec.mem), 9'h000);
    dchk(8'hF6, 8'hE8, 8'h00, alod_pkg::OP_SIGNED_MULTIPLY,
         9'h019, 9'h01C);
    dchk(8'hF6, 8'h28, 8'h00, alod_pkg::OP_SIGNED_MULTIPLY,
         9'h01F, 9'h022);
    chk("mem", 9'(dec.mem), 9'h001);
    chk("word", 9'(dec.word), 9'h000);
    dchk(8'hF7, 8'h28, 8'h00, alod_pkg::OP_SIGNED_MULTIPLY,
         9'h028, 9'h02B);
    dchk(8'h69, 8'hC0, 8'h00, alod_pkg::OP_IMM_MULTIPLY,
         9'h016, 9'h019);
    chk("imm_bytes", 9'(dec.imm_bytes), 9'h002);
    // word-only form: memory figures stand as listed, no word add
    dchk(8'h6B, 8'h00, 8'h00, alod_pkg::OP_IMM_MULTIPLY,
         9'h01D, 9'h020);
    chk("imm_bytes", 9'(dec.imm_bytes), 9'h001);
    chk("word", 9'(dec.word), 9'h001);
    dchk(8'hF6, 8'hF0, 8'h00, alod_pkg::OP_UNSIGNED_DIVIDE,
         9'h01D, 9'h01D);
    dchk(8'hF7, 8'hF0, 8'h00, alod_pkg::OP_UNSIGNED_DIVIDE,
         9'h026, 9'h026);
    dchk(8'hF6, 8'h30, 8'h00, alod_pkg::OP_UNSIGNED_DIVIDE,
         9'h023, 9'h023);
    dchk(8'hF7, 8'h30, 8'h00, alod_pkg::OP_UNSIGNED_DIVIDE,
         9'h02C, 9'h02C);
    dchk(8'hF6, 8'hF8, 8'h00, alod_pkg::OP_SIGNED_DIVIDE,
         9'h02C, 9'h034);
    dchk(8'hF7, 8'hF8, 8'h00, alod_pkg::OP_SIGNED_DIVIDE,
         9'h035, 9'h03D);
    dchk(8'hF6, 8'h38, 8'h00, alod_pkg::OP_SIGNED_DIVIDE,
         9'h032, 9'h03A);
    dchk(8'hF7, 8'h38, 8'h00, alod_pkg::OP_SIGNED_DIVIDE,
         9'h03B, 9'h043);
  endtask

  task automatic t_adjust_extend();
    dchk(8'hD4, 8'h0A, 8'h00, alod_pkg::OP_ASCII_ADJUST_AFTER_MULTIPLY,
         9'h013, 9'h013);
    dchk(8'hD4, 8'h0B, 8'h00, alod_pkg::OP_NONE, 9'h000, 9'h000);
    dchk(8'hD5, 8'h0A, 8'h00, alod_pkg::OP_ASCII_ADJUST_BEFORE_DIVIDE,
         9'h00F, 9'h00F);
    dchk(8'h98, 8'h00, 8'h00, alod_pkg::OP_BYTE_TO_WORD_EXTEND,
         9'h002, 9'h002);
    chk("word", 9'(dec.word), 9'h000);
    chk("mem", 9'(dec.mem), 9'h000);
    dchk(8'h99, 8'h00, 8'h00, alod_pkg::OP_WORD_TO_DWORD_EXTEND,
         9'h004, 9'h004);
    chk("word", 9'(dec.word), 9'h001);
  endtask

  task automatic t_shift();
    logic [7:0] m;
    for (int k = 0; k < 8; k++) begin
      m = {2'h3, 3'(k), 3'h1};
      if (k == 6) begin
        dchk(8'hD0, m, 8'h00, alod_pkg::OP_NONE, 9'h000, 9'h000);
      end else begin
        dchk(8'hD0, m, 8'h00, alod_pkg::OP_SHIFT, 9'h002, 9'h002);
        chk("shift_op", 9'(dec.shift_op), 9'(k));
      end
    end
    dchk(8'hD1, 8'h00, 8'h00, alod_pkg::OP_SHIFT, 9'h013, 9'h013);
    dchk(8'hD2, 8'hC0, 8'h03, alod_pkg::OP_SHIFT, 9'h008, 9'h008);
    dchk(8'hC1, 8'h28, 8'h05, alod_pkg::OP_SHIFT, 9'h01A, 9'h01A);
    chk("shift_op", 9'(dec.shift_op), 9'h005);
  endtask

  task automatic t_logic();
    dchk(8'h20, 8'hC0, 8'h00, alod_pkg::OP_AND, 9'h003, 9'h003);
    dchk(8'h21, 8'h00, 8'h00, alod_pkg::OP_AND, 9'h00E, 9'h00E);
    chk("mem", 9'(dec.mem), 9'h001);
    chk("word", 9'(dec.word), 9'h001);
    dchk(8'h0A, 8'h06, 8'h00, alod_pkg::OP_OR, 9'h00A, 9'h00A);
    dchk(8'h33, 8'hC1, 8'h00, alod_pkg::OP_XOR, 9'h003, 9'h003);
    dchk(8'h85, 8'hC1, 8'h00, alod_pkg::OP_TEST, 9'h003, 9'h003);
    chk("writes", 9'(dec.writes_result), 9'h000);
    dchk(8'hF6, 8'hC0, 8'h00, alod_pkg::OP_TEST, 9'h004, 9'h004);
    chk("imm_bytes", 9'(dec.imm_bytes), 9'h001);
    dchk(8'hF7, 8'h00, 8'h00, alod_pkg::OP_TEST, 9'h00E, 9'h00E);
    chk("imm_bytes", 9'(dec.imm_bytes), 9'h002);
    dchk(8'hA8, 8'h00, 8'h00, alod_pkg::OP_TEST, 9'h003, 9'h003);
    dchk(8'hA9, 8'h00, 8'h00, alod_pkg::OP_TEST, 9'h004, 9'h004);
    chk("mem", 9'(dec.mem), 9'h000);
    dchk(8'hF6, 8'hD0, 8'h00, alod_pkg::OP_INVERT, 9'h003, 9'h003);
    dchk(8'hF7, 8'h10, 8'h00, alod_pkg::OP_INVERT, 9'h00E, 9'h00E);
    dchk(8'h81, 8'hE0, 8'h00, alod_pkg::OP_AND, 9'h004, 9'h004);
    dchk(8'h80, 8'h08, 8'h00, alod_pkg::OP_OR, 9'h010, 9'h010);
    dchk(8'h81, 8'h30, 8'h00, alod_pkg::OP_XOR, 9'h014, 9'h014);
    dchk(8'h83, 8'hC0, 8'h00, alod_pkg::OP_NONE, 9'h000, 9'h000);
    dchk(8'h24, 8'h00, 8'h00, alod_pkg::OP_AND, 9'h003, 9'h003);
    dchk(8'h0D, 8'h00, 8'h00, alod_pkg::OP_OR, 9'h004, 9'h004);
    dchk(8'h34, 8'h00, 8'h00, alod_pkg::OP_XOR, 9'h003, 9'h003);
    dchk(8'h00, 8'hC0, 8'h00, alod_pkg::OP_NONE, 9'h000, 9'h000);
  endtask

  // reset in mid-run must clear the result at once
  task automatic t_reset();
    req.opcode = 8'h99;
    @(negedge clk_sys);
    rstn = 1'b0;
    #1;
    chk("rst_known", 9'(dec.known), 9'h000);
    chk("rst_cyc", dec.cyc_max, 9'h000);
    @(negedge clk_sys);
    rstn = 1'b1;
    dchk(8'h99, 8'h00, 8'h00, alod_pkg::OP_WORD_TO_DWORD_EXTEND,
         9'h004, 9'h004);
  endtask

  initial begin
    repeat (10) @(negedge clk_sys);
    chk("rst_valid", 9'(dec.valid), 9'h000);
    rstn = 1'b1;
    t_muldiv();
    t_adjust_extend();
    t_shift();
    t_logic();
    t_reset();
    req.valid = 1'b0;
    @(negedge clk_sys);
    chk("idle_valid", 9'(dec.valid), 9'h000);
    complete_run();
  end
endmodule
